// >>> shared/e1pm_pkg.sv
// Constants and types shared by the E1 receive error counter bank
package e1pm_pkg;
    // AXI4-Lite address width and register index width
    localparam int AXI_AW = 18;
    localparam int IDX_W = 16;
    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_SYNC_HI = 16'h0905;
    localparam logic [IDX_W-1:0] IDX_SYNC_LO = 16'h0906;
    localparam logic [IDX_W-1:0] IDX_FEBE_HI = 16'h0907;
    localparam logic [IDX_W-1:0] IDX_FEBE_LO = 16'h0908;
    localparam logic [IDX_W-1:0] IDX_SLIP = 16'h0909;
    localparam logic [IDX_W-1:0] IDX_STATUS = 16'h0910;
    localparam logic [IDX_W-1:0] IDX_MASK = 16'h0911;
    // Counter widths
    localparam int SYNC_W = 16;
    localparam int FEBE_W = 16;
    localparam int SLIP_W = 8;
    // Event bit positions in status and mask
    localparam int EVT_N = 3;
    localparam int EVT_SYNC = 0;
    localparam int EVT_FEBE = 1;
    localparam int EVT_SLIP = 2;
    // Values after reset
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [EVT_N-1:0] MASK_RESET = 3'h0;
    localparam logic [EVT_N-1:0] STATUS_RESET = 3'h0;
    // AXI response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // Register selected by a bus address
    typedef enum logic [2:0] {
        SEL_NONE = 3'b000,
        SEL_SYNC_HI = 3'b001,
        SEL_SYNC_LO = 3'b010,
        SEL_FEBE_HI = 3'b011,
        SEL_FEBE_LO = 3'b100,
        SEL_SLIP = 3'b101,
        SEL_STATUS = 3'b110,
        SEL_MASK = 3'b111
    } e1pm_sel_t;
endpackage

// >>> shared/e1pm_cnt_if.sv
// Control and read-back lines between the bank and one counter
`timescale 1ns/1ps
interface e1pm_cnt_if;
    logic inc;
    logic snap;
    logic clear;
    logic [7:0] rd_hi;
    logic [7:0] rd_lo;
    modport bank (output inc, output snap, output clear,
                  input rd_hi, input rd_lo);
    modport cnt (input inc, input snap, input clear,
                 output rd_hi, output rd_lo);
endinterface

// >>> rtl/e1pm_counter.sv
// Saturating clear-on-read event counter with upper/lower byte view
`timescale 1ns/1ps
module e1pm_counter
    import e1pm_pkg::*;
#(
    parameter int WIDTH = FEBE_W
)
(
    input wire logic aclk,
    input wire logic aresetn,
    e1pm_cnt_if.cnt cnt_if
);
    // Two-byte counters keep a shadow between the byte reads
    localparam bit SPLIT = (WIDTH > 8);

    if (WIDTH != 8 && WIDTH != 16)
    begin : g_chk
        $error("e1pm_counter: WIDTH must be 8 or 16");
    end

    logic [WIDTH-1:0] count_r;   // Live count
    logic [WIDTH-1:0] count_nxt; // Next live count
    logic [WIDTH-1:0] shadow_r;  // Count seen by upper-byte read
    logic armed_r;               // Upper byte read, lower pending
    logic clear_eff;             // Clear that really takes effect
    logic [WIDTH-1:0] base;      // Count after any clear
    logic [15:0] wide;           // Count widened for the byte view

    // Add one unless already all ones
    function automatic logic [WIDTH-1:0] sat_inc(
        input logic [WIDTH-1:0] v,
        input logic inc);
        sat_inc = (inc && v != '1) ? v + 1'b1 : v;
    endfunction

    // ==========================================================
    // Next count
    // ==========================================================
    always_comb
    begin
        clear_eff = cnt_if.clear && (!SPLIT || armed_r);
        // Keep events that came after the upper-byte read
        base = count_r;
        if (clear_eff)
            base = SPLIT ? count_r - shadow_r : '0;
        count_nxt = sat_inc(base, cnt_if.inc);
    end

    // Live count
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            count_r <= WIDTH'(CNT_RESET);
        else
            count_r <= count_nxt;
    end

    // Shadow and pending flag for ordered byte reads
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            shadow_r <= WIDTH'(CNT_RESET);
            armed_r <= 1'b0;
        end
        else if (cnt_if.snap && SPLIT)
        begin
            shadow_r <= count_r;
            armed_r <= 1'b1;
        end
        else if (cnt_if.clear)
            armed_r <= 1'b0;
    end

    // Byte view; lower byte comes from the shadow when pending
    assign wide = 16'(count_r);
    assign cnt_if.rd_hi = SPLIT ? wide[15:8] : 8'h00;
    assign cnt_if.rd_lo = armed_r ? shadow_r[7:0] : count_r[7:0];

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_sat_hold:
        assert property (count_r == '1 && !cnt_if.clear
                         |=> count_r == '1)
        else $error("counter left all ones without a clear");
    a_step_one:
        assert property (cnt_if.inc && !cnt_if.clear && count_r != '1
                         |=> count_r == $past(count_r) + 1'b1)
        else $error("counter did not step by one");
    a_clear_keeps:
        assert property (clear_eff && cnt_if.inc && base != '1
                         |=> count_r == $past(base) + 1'b1)
        else $error("event lost on clearing read");
endmodule

// >>> rtl/e1pm_irq.sv
// Sticky event status, mask and level interrupt
`timescale 1ns/1ps
module e1pm_irq
    import e1pm_pkg::*;
#(
    parameter int N = EVT_N
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [N-1:0] evt,
    input wire logic rd_clr,
    input wire logic wr_mask,
    input wire logic [N-1:0] wr_data,
    output logic [N-1:0] status,
    output logic [N-1:0] mask,
    output logic irq
);
    if (N != EVT_N)
    begin : g_chk
        $error("e1pm_irq: N must match the event count");
    end

    // Sticky bits; a new event wins over the clearing read
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            status <= STATUS_RESET;
        else
            status <= (rd_clr ? '0 : status) | evt;
    end

    // Mask, written by software
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            mask <= MASK_RESET;
        else if (wr_mask)
            mask <= wr_data;
    end

    // Level interrupt while any unmasked bit is set
    assign irq = |(status & mask);

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_set_wins:
        assert property (rd_clr |=> status == $past(evt))
        else $error("status not cleared or event lost");
endmodule

// >>> rtl/e1pm_bank.sv
// E1 receive error counter bank with AXI4-Lite register port
//
// Notes on behaviour
// - counters restart from zero after read
// - sync error count sixteen bits, two bytes
// - sync error counter steps per framer error
// - upper then lower read clears count
// - far-end count sixteen bits, two bytes
// - far-end counter steps on zero E-bit
// - no far-end counting while frame/CRC lost
// - signalling multiframe loss keeps far-end counting
// - slip counter eight bits, counts every slip
// - frame repeat or discard is one slip
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module e1pm_bank
    import e1pm_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [AXI_AW-1:0] awaddr,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [AXI_AW-1:0] araddr,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Receive framer events, same clock
    input wire logic sync_bit_error,
    input wire logic e_bit_strobe,
    input wire logic e_bit_value,
    input wire logic frame_align_lost,
    input wire logic crc_mf_align_lost,
    // Receive slip buffer events, same clock
    input wire logic slip_repeat,
    input wire logic slip_delete,
    // Interrupt
    output logic irq
);
    // ==========================================================
    // Declarations
    // ==========================================================
    logic aw_held_r;              // Write address taken
    logic w_held_r;               // Write data taken
    logic [AXI_AW-1:0] awaddr_r;  // Held write address
    logic [31:0] wdata_r;         // Held write data
    logic [3:0] wstrb_r;          // Held byte strobes
    logic bvalid_r;               // Write answer pending
    logic [1:0] bresp_r;          // Write answer code
    logic rvalid_r;               // Read answer pending
    logic [31:0] rdata_r;         // Read data
    logic [1:0] rresp_r;          // Read answer code
    logic rd_fire;                // Read address taken now
    logic wr_fire;                // Write performed now
    e1pm_sel_t rd_sel;            // Register being read
    e1pm_sel_t wr_sel;            // Register being written
    logic [7:0] rd_byte;          // Byte returned by the read
    logic febe_evt;               // Qualified far-end block error
    logic slip_evt;               // One slip of the receive buffer
    logic [EVT_N-1:0] evt;        // Events to status
    logic [EVT_N-1:0] status;     // Sticky status
    logic [EVT_N-1:0] mask;       // Interrupt mask

    // Counter links
    e1pm_cnt_if sync_if();
    e1pm_cnt_if febe_if();
    e1pm_cnt_if slip_if();

    // Map a byte address to the register it selects
    function automatic e1pm_sel_t decode(
        input logic [AXI_AW-1:0] addr);
        logic [IDX_W-1:0] idx;
        idx = addr[AXI_AW-1:2];
        unique case (idx)
            IDX_SYNC_HI: decode = SEL_SYNC_HI;
            IDX_SYNC_LO: decode = SEL_SYNC_LO;
            IDX_FEBE_HI: decode = SEL_FEBE_HI;
            IDX_FEBE_LO: decode = SEL_FEBE_LO;
            IDX_SLIP: decode = SEL_SLIP;
            IDX_STATUS: decode = SEL_STATUS;
            IDX_MASK: decode = SEL_MASK;
            default: decode = SEL_NONE;
        endcase
    endfunction

    // ==========================================================
    // Event qualification
    // ==========================================================
    // Far-end error only with frame and CRC alignment held;
    // signalling multiframe loss is deliberately not a term
    assign febe_evt = e_bit_strobe && !e_bit_value
                      && !frame_align_lost && !crc_mf_align_lost;
    // Repeat and discard are both one slip
    assign slip_evt = slip_repeat || slip_delete;

    assign evt[EVT_SYNC] = sync_bit_error;
    assign evt[EVT_FEBE] = febe_evt;
    assign evt[EVT_SLIP] = slip_evt;

    // ==========================================================
    // Counters
    // ==========================================================
    // Increment requests
    assign sync_if.inc = sync_bit_error;
    assign febe_if.inc = febe_evt;
    assign slip_if.inc = slip_evt;

    // Upper-byte read takes the snapshot
    assign sync_if.snap = rd_fire && rd_sel == SEL_SYNC_HI;
    assign febe_if.snap = rd_fire && rd_sel == SEL_FEBE_HI;
    assign slip_if.snap = 1'b0;

    // Lower-byte read after the upper byte, or single read, clears
    assign sync_if.clear = rd_fire && rd_sel == SEL_SYNC_LO;
    assign febe_if.clear = rd_fire && rd_sel == SEL_FEBE_LO;
    assign slip_if.clear = rd_fire && rd_sel == SEL_SLIP;

    // Synchronization bit error count
    e1pm_counter #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .cnt_if(sync_if)
    );

    // Far-end block error count
    e1pm_counter #(
        .WIDTH(FEBE_W)
    ) u_febe (
        .aclk(aclk),
        .aresetn(aresetn),
        .cnt_if(febe_if)
    );

    // Receive slip count
    e1pm_counter #(
        .WIDTH(SLIP_W)
    ) u_slip (
        .aclk(aclk),
        .aresetn(aresetn),
        .cnt_if(slip_if)
    );

    // ==========================================================
    // Status, mask and interrupt
    // ==========================================================
    e1pm_irq #(
        .N(EVT_N)
    ) u_irq (
        .aclk(aclk),
        .aresetn(aresetn),
        .evt(evt),
        .rd_clr(rd_fire && rd_sel == SEL_STATUS),
        .wr_mask(wr_fire && wr_sel == SEL_MASK && wstrb_r[0]),
        .wr_data(wdata_r[EVT_N-1:0]),
        .status(status),
        .mask(mask),
        .irq(irq)
    );

    // ==========================================================
    // Read channel
    // ==========================================================
    // One read at a time; address taken only when idle
    assign arready = !rvalid_r;
    assign rd_fire = arvalid && arready;
    assign rd_sel = decode(araddr);

    // Byte seen by the current read
    always_comb
    begin
        unique case (rd_sel)
            SEL_NONE: rd_byte = 8'h00;
            SEL_SYNC_HI: rd_byte = sync_if.rd_hi;
            SEL_SYNC_LO: rd_byte = sync_if.rd_lo;
            SEL_FEBE_HI: rd_byte = febe_if.rd_hi;
            SEL_FEBE_LO: rd_byte = febe_if.rd_lo;
            SEL_SLIP: rd_byte = slip_if.rd_lo;
            SEL_STATUS: rd_byte = 8'(status);
            SEL_MASK: rd_byte = 8'(mask);
        endcase
    end

    // Read answer one cycle after the address is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= RESP_OKAY;
        end
        else if (rd_fire)
        begin
            rvalid_r <= 1'b1;
            rdata_r <= {24'h000000, rd_byte};
            // Unmapped address answers with a decode error
            rresp_r <= (rd_sel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
        end
        else if (rready)
            rvalid_r <= 1'b0;
    end

    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;

    // ==========================================================
    // Write channel
    // ==========================================================
    // Address and data taken in either order, held until used
    assign awready = !aw_held_r && !bvalid_r;
    assign wready = !w_held_r && !bvalid_r;
    assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
    assign wr_sel = decode(awaddr_r);

    // Write address holding
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r <= 1'b0;
            awaddr_r <= '0;
        end
        else if (awvalid && awready)
        begin
            aw_held_r <= 1'b1;
            awaddr_r <= awaddr;
        end
        else if (wr_fire)
            aw_held_r <= 1'b0;
    end

    // Write data holding
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held_r <= 1'b0;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
        end
        else if (wvalid && wready)
        begin
            w_held_r <= 1'b1;
            wdata_r <= wdata;
            wstrb_r <= wstrb;
        end
        else if (wr_fire)
            w_held_r <= 1'b0;
    end

    // Write answer; only the mask is writable
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_r <= 1'b1;
            if (wr_sel == SEL_NONE)
                bresp_r <= RESP_DECERR;
            else if (wr_sel == SEL_MASK)
                bresp_r <= RESP_OKAY;
            else
                bresp_r <= RESP_SLVERR; // Counters are read-only
        end
        else if (bready)
            bvalid_r <= 1'b0;
    end

    assign bvalid = bvalid_r;
    assign bresp = bresp_r;

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Read address accepted
    sequence s_read_req;
        arvalid && arready;
    endsequence

    // Lower-byte read of the far-end count after its upper byte
    // Reads are at least two cycles apart, so the next one is the pair
    sequence s_febe_pair;
        rd_fire && rd_sel == SEL_FEBE_HI
        ##[2:3] rd_fire && rd_sel == SEL_FEBE_LO;
    endsequence

    a_read_answer:
        assert property (s_read_req |=> rvalid && !arready)
        else $error("read not answered next cycle");
    a_read_holds:
        assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data changed before taken");
    a_febe_gated:
        assert property ((frame_align_lost || crc_mf_align_lost)
                         && !rd_fire |=> $stable(febe_if.rd_lo))
        else $error("far-end count moved while alignment lost");
    a_febe_counts:
        assert property (e_bit_strobe && !e_bit_value
                         && !frame_align_lost && !crc_mf_align_lost
                         && !rd_fire && u_febe.count_r != 16'hFFFF
                         |=> u_febe.count_r == $past(u_febe.count_r) + 1'b1)
        else $error("far-end count missed a zero E-bit");
    a_febe_cas_on:
        assert property (e_bit_strobe && !e_bit_value
                         && !frame_align_lost && !crc_mf_align_lost
                         |-> febe_evt)
        else $error("far-end count blocked without frame loss");
    a_slip_counts:
        assert property (slip_evt && !rd_fire && slip_if.rd_lo != 8'hFF
                         |=> slip_if.rd_lo == $past(slip_if.rd_lo) + 8'h01)
        else $error("slip counter missed a slip");
    a_slip_clears:
        assert property (s_read_req and rd_sel == SEL_SLIP
                         |=> slip_if.rd_lo == 8'($past(slip_evt)))
        else $error("slip count not restarted by read");
    a_pair_clears:
        assert property (s_febe_pair
                         |=> febe_if.rd_hi == 8'h00)
        else $error("ordered read pair left upper byte");
    a_irq_raise:
        assert property (sync_bit_error && mask[EVT_SYNC]
                         && !(wr_fire && wr_sel == SEL_MASK) |=> irq)
        else $error("unmasked event did not raise interrupt");
    a_unmapped_err:
        assert property (s_read_req and rd_sel == SEL_NONE
                         |=> rresp == RESP_DECERR)
        else $error("unmapped read not refused");
    a_write_holds:
        assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer changed before taken");
endmodule

// >>> testbench/e1pm_bank_test.sv
// Self-checking bench for the E1 receive error counter bank
`timescale 1ns/1ps
module e1pm_bank_test
    import e1pm_pkg::*;
;
    // ==========
    // Stimulus and observed signals
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp;
    logic sync_bit_error = 1'b0, e_bit_strobe = 1'b0, e_bit_value = 1'b1;
    logic frame_align_lost = 1'b0, crc_mf_align_lost = 1'b0;
    logic slip_repeat = 1'b0, slip_delete = 1'b0;
    int mismatches = 0;
    int checked = 0;
    e1pm_bank e1pm_bank_i (.aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .sync_bit_error(sync_bit_error), .e_bit_strobe(e_bit_strobe),
        .e_bit_value(e_bit_value), .frame_align_lost(frame_align_lost),
        .crc_mf_align_lost(crc_mf_align_lost), .slip_repeat(slip_repeat),
        .slip_delete(slip_delete), .irq(irq));
    // ==========
    // Clock, 100 MHz
    initial
    begin
        forever #5 aclk = ~aclk;
    end
    // ==========
    // Tasks
    // Verdict and end of run
    task final_report();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Compare seen against expected
    task check(input string nm, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // One AXI4-Lite read, checked for data and response
    task rd(input string nm, input logic [IDX_W-1:0] idx,
            input logic [31:0] exp, input logic [1:0] er);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= {idx, 2'b00};
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge aclk);
        rready <= 1'b0;
        check(nm, rdata, exp);
        check("rresp", {30'h0, rresp}, {30'h0, er});
    endtask
    // One AXI4-Lite write, checked for response
    task wr(input logic [IDX_W-1:0] idx, input logic [31:0] d,
            input logic [1:0] er);
        logic a, w;
        a = 1'b0;
        w = 1'b0;
        @(posedge aclk);
        {awvalid, wvalid, bready} <= 3'h7;
        awaddr <= {idx, 2'b00};
        wdata <= d;
        while (!(a && w))
        begin
            @(posedge aclk);
            if (awvalid && awready) a = 1'b1;
            if (wvalid && wready) w = 1'b1;
            if (a) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end
        while (!bvalid) @(posedge aclk);
        bready <= 1'b0;
        check("bresp", {30'h0, bresp}, {30'h0, er});
    endtask
    // Event pulses, n back-to-back cycles of kind k
    task ev(input int k, input int n);
        @(posedge aclk);
        case (k)
            0: sync_bit_error <= 1'b1;
            1: {e_bit_strobe, e_bit_value} <= 2'b10;
            2: {e_bit_strobe, e_bit_value} <= 2'b11;
            3: slip_repeat <= 1'b1;
            4: slip_delete <= 1'b1;
            default: {slip_repeat, slip_delete} <= 2'b11;
        endcase
        repeat (n) @(posedge aclk);
        {sync_bit_error, e_bit_strobe, slip_repeat, slip_delete} <= 4'h0;
        e_bit_value <= 1'b1;
    endtask
    // ==========
    // Watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        final_report();
    end
    // ==========
    // Test sequence
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset values of every register
        for (int i = 0; i < 5; i++)
            rd("cnt_reset", IDX_W'(IDX_SYNC_HI + i), 32'h0, RESP_OKAY);
        rd("status_reset", IDX_STATUS, 32'h0, RESP_OKAY);
        rd("mask_reset", IDX_MASK, 32'h0, RESP_OKAY);
        // Sync errors, ordered pair read then cleared
        ev(0, 3);
        rd("sync_hi", IDX_SYNC_HI, 32'h0, RESP_OKAY);
        rd("sync_lo", IDX_SYNC_LO, 32'h3, RESP_OKAY);
        rd("sync_hi2", IDX_SYNC_HI, 32'h0, RESP_OKAY);
        rd("sync_lo2", IDX_SYNC_LO, 32'h0, RESP_OKAY);
        // Lower byte alone does not clear
        ev(0, 2);
        rd("sync_lo_only", IDX_SYNC_LO, 32'h2, RESP_OKAY);
        rd("sync_lo_kept", IDX_SYNC_LO, 32'h2, RESP_OKAY);
        rd("sync_hi3", IDX_SYNC_HI, 32'h0, RESP_OKAY);
        rd("sync_lo3", IDX_SYNC_LO, 32'h2, RESP_OKAY);
        rd("sync_lo4", IDX_SYNC_LO, 32'h0, RESP_OKAY);
        // Far-end count over a byte, gated by alignment loss
        ev(1, 300);
        ev(2, 5);
        frame_align_lost <= 1'b1;
        ev(1, 4);
        frame_align_lost <= 1'b0;
        crc_mf_align_lost <= 1'b1;
        ev(1, 4);
        crc_mf_align_lost <= 1'b0;
        rd("febe_hi", IDX_FEBE_HI, 32'h01, RESP_OKAY);
        rd("febe_lo", IDX_FEBE_LO, 32'h2C, RESP_OKAY);
        rd("febe_hi2", IDX_FEBE_HI, 32'h0, RESP_OKAY);
        rd("febe_lo2", IDX_FEBE_LO, 32'h0, RESP_OKAY);
        // Slip counter saturates, then each slip kind counts once
        ev(3, 300);
        rd("slip_sat", IDX_SLIP, 32'hFF, RESP_OKAY);
        ev(3, 1);
        ev(4, 1);
        ev(5, 1);
        rd("slip_kinds", IDX_SLIP, 32'h3, RESP_OKAY);
        rd("slip_clear", IDX_SLIP, 32'h0, RESP_OKAY);
        // Interrupt raised, masked and cleared
        rd("status_all", IDX_STATUS, 32'h7, RESP_OKAY);
        wr(IDX_MASK, 32'h4, RESP_OKAY);
        rd("mask", IDX_MASK, 32'h4, RESP_OKAY);
        ev(0, 1);
        @(posedge aclk);
        check("irq_masked", {31'h0, irq}, 32'h0);
        ev(4, 1);
        @(posedge aclk);
        check("irq_set", {31'h0, irq}, 32'h1);
        rd("status", IDX_STATUS, 32'h5, RESP_OKAY);
        check("irq_clear", {31'h0, irq}, 32'h0);
        // Unmasked sync event raises the interrupt
        wr(IDX_MASK, 32'h1, RESP_OKAY);
        ev(0, 1);
        @(posedge aclk);
        check("irq_sync", {31'h0, irq}, 32'h1);
        // Mask write without its byte strobe is ignored
        wstrb <= 4'h0;
        wr(IDX_MASK, 32'h0, RESP_OKAY);
        wstrb <= 4'hF;
        rd("mask_kept", IDX_MASK, 32'h1, RESP_OKAY);
        // Refused and unmapped accesses
        wr(IDX_SYNC_HI, 32'hFF, RESP_SLVERR);
        wr(16'h0100, 32'h1, RESP_DECERR);
        rd("unmapped", 16'h0100, 32'h0, RESP_DECERR);
        rd("slip_left", IDX_SLIP, 32'h1, RESP_OKAY);
        // Slip in the cycle of the clearing read is kept
        slip_repeat <= 1'b1;
        rd("slip_overlap", IDX_SLIP, 32'h1, RESP_OKAY);
        slip_repeat <= 1'b0;
        rd("slip_kept", IDX_SLIP, 32'h2, RESP_OKAY);
        final_report();
    end
endmodule
